// ### hw/ldc_l1_data_cache.sv
// Two-way level1 data cache with snoop writes from the slave DMA port
//
// Notes on behaviour
// - Cache is two-way set associative; a line lives in one of two ways.
// - Dirty lines leave only on victim eviction or software write-back.
// - Slave DMA port requests are external-master traffic, not CPU traffic.
// - DMA update of level2 RAM held in cache starts a snoop write.
// - Two CPU reads per cycle are accepted; a miss allocates unless port 0 misses on the same line.
// - Replacing a line with a pending snoop cancels that snoop.
// - Replaced line's snooped content is dropped; late snoop never overwrites.
// - Line size is 64 bytes so 64-byte aligned buffers never share.
// - Level2 memory may be all cache, all RAM, or mixed.
// - Level1 data RAM may be all plain RAM, disabling caching.
// - DMA may target level1 data RAM or shared RAM instead of level2.
module ldc_l1_data_cache #(
    parameter int SET_W = ldc_pkg::SET_W_DEF,
    parameter int DATA_W = ldc_pkg::DATA_W_DEF,
    parameter int CNT_W = ldc_pkg::CNT_W_DEF,
    parameter int SNOOP_LAT = ldc_pkg::SNOOP_LAT_DEF,
    parameter int SPLIT_BIT = ldc_pkg::L2_SPLIT_BIT_DEF
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic l1RamMode,
    input wire ldc_pkg::ldc_l2mode_e l2Mode,
    input wire logic rd0Valid,
    input wire logic [ldc_pkg::ADDR_W-1:0] rd0Addr,
    input wire logic [DATA_W-1:0] rd0Fill,
    input wire logic rd1Valid,
    input wire logic [ldc_pkg::ADDR_W-1:0] rd1Addr,
    input wire logic [DATA_W-1:0] rd1Fill,
    input wire logic wrValid,
    input wire logic [ldc_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic dmaValid,
    input wire ldc_pkg::ldc_target_e dmaTarget,
    input wire logic [ldc_pkg::ADDR_W-1:0] dmaAddr,
    input wire logic [DATA_W-1:0] dmaData,
    input wire logic wbReq,
    input wire logic [ldc_pkg::ADDR_W-1:0] wbAddr,
    input wire logic [CNT_W-1:0] wbLines,
    output logic cpuReady,
    output logic dmaReady,
    output logic rd0Done,
    output logic rd0Hit,
    output logic [DATA_W-1:0] rd0Data,
    output logic rd1Done,
    output logic rd1Hit,
    output logic [DATA_W-1:0] rd1Data,
    output logic ev0Valid,
    output logic [ldc_pkg::ADDR_W-1:0] ev0Addr,
    output logic [DATA_W-1:0] ev0Data,
    output logic ev1Valid,
    output logic [ldc_pkg::ADDR_W-1:0] ev1Addr,
    output logic [DATA_W-1:0] ev1Data,
    output logic wtValid,
    output logic [ldc_pkg::ADDR_W-1:0] wtAddr,
    output logic [DATA_W-1:0] wtData,
    output logic wbDone
);
    localparam int AW = ldc_pkg::ADDR_W;
    localparam int OW = ldc_pkg::OFF_W;
    localparam int SETS = 1 << SET_W;
    localparam int TAG_W = AW - OW - SET_W;
    localparam int NLK = 5;

    // Decoders shared by every lookup
    function automatic logic [SET_W-1:0] setOf(input logic [AW-1:0] a);
        return a[OW +: SET_W];
    endfunction
    function automatic logic [TAG_W-1:0] tagOf(input logic [AW-1:0] a);
        return a[AW-1 -: TAG_W];
    endfunction

    logic vArr [ldc_pkg::WAYS][SETS];
    logic dArr [ldc_pkg::WAYS][SETS];
    logic [TAG_W-1:0] tArr [ldc_pkg::WAYS][SETS];
    logic [DATA_W-1:0] datArr [ldc_pkg::WAYS][SETS];
    logic lruArr [SETS];

    logic cpuReady_reg, dmaReady_reg, wbDone_reg;
    logic rdDone_reg [2];
    logic rdHit_reg [2];
    logic [DATA_W-1:0] rdData_reg [2];
    logic evValid_reg [2];
    logic [AW-1:0] evAddr_reg [2];
    logic [DATA_W-1:0] evData_reg [2];
    logic wtValid_reg;
    logic [AW-1:0] wtAddr_reg;
    logic [DATA_W-1:0] wtData_reg;
    ldc_pkg::ldc_walk_e walk_reg;
    logic [AW-1:0] walkAddr_reg;
    logic [CNT_W-1:0] walkLeft_reg;

    logic [AW-1:0] la [NLK];
    logic lhit [NLK];
    logic lway [NLK];
    logic rdV [2];
    logic [AW-1:0] rdA [2];
    logic [DATA_W-1:0] rdF [2];
    logic alloc [2];
    logic vw [2];
    logic [SET_W-1:0] rs [2];
    logic dmaFire, inL2Ram, snoopStart, kill, walkHit, wrHit;
    logic slotBusy, slotDone, slotWay, kWay;
    logic [SET_W-1:0] slotSet, kSet;
    logic [DATA_W-1:0] slotData;

    assign rdV[0] = rd0Valid && cpuReady_reg;
    assign rdV[1] = rd1Valid && cpuReady_reg;
    assign rdA[0] = rd0Addr;
    assign rdA[1] = rd1Addr;
    assign rdF[0] = rd0Fill;
    assign rdF[1] = rd1Fill;
    assign la[0] = rd0Addr;
    assign la[1] = rd1Addr;
    assign la[2] = dmaAddr;
    assign la[3] = walkAddr_reg;
    assign la[4] = wrAddr;
    assign rs[0] = setOf(rd0Addr);
    assign rs[1] = setOf(rd1Addr);

    ////////////////////////////////////////////////////////////////////////
    // Tag lookups; in plain RAM mode nothing ever hits
    generate
        for (genvar i = 0; i < NLK; i++) begin : g_lk
            logic m0, m1;
            assign m0 = vArr[0][setOf(la[i])]
                && tArr[0][setOf(la[i])] == tagOf(la[i]);
            assign m1 = vArr[1][setOf(la[i])]
                && tArr[1][setOf(la[i])] == tagOf(la[i]);
            assign lhit[i] = !l1RamMode && (m0 || m1);
            assign lway[i] = m1;
        end
    endgenerate

    // Victim choice; two misses into one set take different ways
    always_comb begin
        alloc[0] = rdV[0] && !lhit[0] && !l1RamMode;
        alloc[1] = rdV[1] && !lhit[1] && !l1RamMode
            && !(alloc[0] && rd0Addr[AW-1:OW] == rd1Addr[AW-1:OW]);
        vw[0] = lruArr[rs[0]];
        if (lhit[1] && rdV[1] && rs[1] == rs[0]) begin
            vw[0] = !lway[1];
        end
        vw[1] = lruArr[rs[1]];
        if (alloc[0] && rs[1] == rs[0]) begin
            vw[1] = !vw[0];
        end
    end

    // Slave-port traffic is classified by target and level2 partitioning
    always_comb begin
        case (l2Mode)
            ldc_pkg::L2_ALL_RAM: inL2Ram = 1'b1;
            ldc_pkg::L2_MIXED: inL2Ram = !dmaAddr[SPLIT_BIT];
            default: inL2Ram = 1'b0;
        endcase
    end
    assign dmaFire = dmaValid && dmaReady_reg;
    assign snoopStart = dmaFire && dmaTarget == ldc_pkg::TGT_L2_RAM
        && inL2Ram && lhit[2];
    assign walkHit = walk_reg == ldc_pkg::WALK_SCAN && lhit[3];
    assign wrHit = wrValid && cpuReady_reg && lhit[4];

    // A fill or invalidate of the line, even as its snoop starts, kills it
    assign kSet = slotBusy ? slotSet : setOf(dmaAddr);
    assign kWay = slotBusy ? slotWay : lway[2];
    assign kill = (slotBusy || snoopStart) && (
        (alloc[0] && vw[0] == kWay && rs[0] == kSet)
        || (alloc[1] && vw[1] == kWay && rs[1] == kSet)
        || (walkHit && lway[3] == kWay
            && setOf(walkAddr_reg) == kSet));

    ldc_snoop_slot #(
        .SET_W(SET_W),
        .DATA_W(DATA_W),
        .LAT(SNOOP_LAT)
    ) u_slot (
        .core_clk(core_clk),
        .srst(srst),
        .start(snoopStart),
        .startSet(setOf(dmaAddr)),
        .startWay(lway[2]),
        .startData(dmaData),
        .kill(kill),
        .busy(slotBusy),
        .done(slotDone),
        .set(slotSet),
        .way(slotWay),
        .data(slotData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Line state: valid, dirty, tag, replacement order
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int s = 0; s < SETS; s++) begin
                lruArr[s] <= ldc_pkg::RST_LRU;
                for (int w = 0; w < ldc_pkg::WAYS; w++) begin
                    vArr[w][s] <= ldc_pkg::RST_VALID;
                    dArr[w][s] <= ldc_pkg::RST_DIRTY;
                end
            end
        end else begin
            if (wrHit) begin
                dArr[lway[4]][setOf(wrAddr)] <= 1'b1;
                lruArr[setOf(wrAddr)] <= !lway[4];
            end
            for (int p = 0; p < 2; p++) begin
                if (rdV[p] && lhit[p]) begin
                    lruArr[rs[p]] <= !lway[p];
                end
                if (alloc[p]) begin
                    vArr[vw[p]][rs[p]] <= 1'b1;
                    dArr[vw[p]][rs[p]] <= 1'b0;
                    tArr[vw[p]][rs[p]] <= tagOf(rdA[p]);
                    lruArr[rs[p]] <= !vw[p];
                end
            end
            if (walkHit) begin
                vArr[lway[3]][setOf(walkAddr_reg)] <= 1'b0;
                dArr[lway[3]][setOf(walkAddr_reg)] <= 1'b0;
            end
        end
    end

    // Line data; fills are written last so they beat a same-cycle write
    always_ff @(posedge core_clk) begin
        if (slotDone) begin
            datArr[slotWay][slotSet] <= slotData;
        end
        if (wrHit) begin
            datArr[lway[4]][setOf(wrAddr)] <= wrData;
        end
        for (int p = 0; p < 2; p++) begin
            if (alloc[p]) begin
                datArr[vw[p]][rs[p]] <= rdF[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read answers and victim write-backs, one lane per read port
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int p = 0; p < 2; p++) begin
                rdDone_reg[p] <= 1'b0;
                rdHit_reg[p] <= 1'b0;
                rdData_reg[p] <= '0;
                evValid_reg[p] <= 1'b0;
                evAddr_reg[p] <= '0;
                evData_reg[p] <= '0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                rdDone_reg[p] <= rdV[p];
                rdHit_reg[p] <= rdV[p] && lhit[p];
                rdData_reg[p] <= lhit[p] ? datArr[lway[p]][rs[p]] : rdF[p];
                evValid_reg[p] <= alloc[p] && vArr[vw[p]][rs[p]]
                    && dArr[vw[p]][rs[p]];
                evAddr_reg[p] <= {tArr[vw[p]][rs[p]], rs[p], OW'(0)};
                evData_reg[p] <= datArr[vw[p]][rs[p]];
            end
            // Walk never overlaps CPU reads, so lane 0 is free for it
            if (walkHit) begin
                evValid_reg[0] <= dArr[lway[3]][setOf(walkAddr_reg)];
                evAddr_reg[0] <= {walkAddr_reg[AW-1:OW], OW'(0)};
                evData_reg[0] <= datArr[lway[3]][setOf(walkAddr_reg)];
            end
        end
    end

    // Write misses go straight out; no allocation on write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wtValid_reg <= 1'b0;
            wtAddr_reg <= '0;
            wtData_reg <= '0;
        end else begin
            wtValid_reg <= wrValid && cpuReady_reg && !lhit[4];
            wtAddr_reg <= wrAddr;
            wtData_reg <= wrData;
        end
    end

    // One snoop in flight; the port holds off while the slot stays busy
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dmaReady_reg <= 1'b1;
        end else begin
            dmaReady_reg <= !(snoopStart
                || (slotBusy && !slotDone && !kill));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Block write-back-invalidate walk, one line per cycle, CPU held off
    always_ff @(posedge core_clk) begin
        if (srst) begin
            walk_reg <= ldc_pkg::WALK_IDLE;
            walkAddr_reg <= '0;
            walkLeft_reg <= '0;
            cpuReady_reg <= 1'b1;
            wbDone_reg <= 1'b0;
        end else begin
            wbDone_reg <= 1'b0;
            case (walk_reg)
                ldc_pkg::WALK_IDLE: begin
                    if (wbReq && wbLines == '0) begin
                        wbDone_reg <= 1'b1;
                    end else if (wbReq) begin
                        walk_reg <= ldc_pkg::WALK_SCAN;
                        walkAddr_reg <= {wbAddr[AW-1:OW], OW'(0)};
                        walkLeft_reg <= wbLines;
                        cpuReady_reg <= 1'b0;
                    end
                end
                ldc_pkg::WALK_SCAN: begin
                    walkAddr_reg <= walkAddr_reg
                        + AW'(ldc_pkg::LINE_BYTES);
                    walkLeft_reg <= walkLeft_reg - 1'b1;
                    if (walkLeft_reg == CNT_W'(1)) begin
                        walk_reg <= ldc_pkg::WALK_IDLE;
                        cpuReady_reg <= 1'b1;
                        wbDone_reg <= 1'b1;
                    end
                end
                default: walk_reg <= ldc_pkg::WALK_IDLE;
            endcase
        end
    end

    assign cpuReady = cpuReady_reg;
    assign dmaReady = dmaReady_reg;
    assign rd0Done = rdDone_reg[0];
    assign rd0Hit = rdHit_reg[0];
    assign rd0Data = rdData_reg[0];
    assign rd1Done = rdDone_reg[1];
    assign rd1Hit = rdHit_reg[1];
    assign rd1Data = rdData_reg[1];
    assign ev0Valid = evValid_reg[0];
    assign ev0Addr = evAddr_reg[0];
    assign ev0Data = evData_reg[0];
    assign ev1Valid = evValid_reg[1];
    assign ev1Addr = evAddr_reg[1];
    assign ev1Data = evData_reg[1];
    assign wtValid = wtValid_reg;
    assign wtAddr = wtAddr_reg;
    assign wtData = wtData_reg;
    assign wbDone = wbDone_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the guarded behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_two_way_victim: assert property (
        alloc[0] && alloc[1] && rs[0] == rs[1] |-> vw[0] != vw[1])
        else $error("two fills chose one way");
    a_dirty_victim_out: assert property (
        alloc[0] && vArr[vw[0]][rs[0]] && dArr[vw[0]][rs[0]]
        |=> ev0Valid && ev0Addr[AW-1:OW] == $past({tArr[vw[0]][rs[0]], rs[0]}))
        else $error("dirty victim not written back");
    a_dma_start_snoop: assert property (
        snoopStart && !kill |=> slotBusy && !dmaReady)
        else $error("snoop not started");
    a_other_target: assert property (
        dmaFire && dmaTarget != ldc_pkg::TGT_L2_RAM |-> !snoopStart)
        else $error("snoop for non level2 target");
    a_all_cache: assert property (
        l2Mode == ldc_pkg::L2_ALL_CACHE |-> !snoopStart)
        else $error("snoop with level2 all cache");
    a_two_reads: assert property (
        rdV[0] && rdV[1] |=> rd0Done && rd1Done)
        else $error("dual read not answered");
    a_snoop_kill: assert property (
        kill |-> !slotDone ##1 !slotBusy)
        else $error("snoop survived replacement");
    a_fill_kept: assert property (
        alloc[0] ##1 slotBusy [*2]
        |-> datArr[$past(vw[0], 2)][$past(rs[0], 2)] == $past(rdF[0], 2))
        else $error("fill data overwritten");
    a_ram_mode: assert property (
        l1RamMode && rdV[0] |=> !rd0Hit)
        else $error("hit in plain RAM mode");
    a_wb_done: assert property (
        wbReq && walk_reg == ldc_pkg::WALK_IDLE
        |-> ##[0:260] wbDone)
        else $error("write-back never completed");

    c_dual_read: cover property (rdV[0] && rdV[1] && alloc[0] && alloc[1]);
    c_snoop_done: cover property (slotDone);
    c_snoop_kill: cover property (kill);
    c_walk_evict: cover property (walkHit ##1 ev0Valid);

endmodule // ldc_l1_data_cache

// ### hw/ldc_pkg.sv
// Shared constants and types for the level-one data cache with snoop logic
package ldc_pkg;

    // Address and line geometry; a line is 64 bytes wide
    localparam int ADDR_W = 32;
    localparam int LINE_BYTES = 64;
    localparam int OFF_W = 6;
    localparam int WAYS = 2;

    // Defaults for module parameters
    localparam int SET_W_DEF = 6;
    localparam int DATA_W_DEF = 32;
    localparam int CNT_W_DEF = 8;
    localparam int L2_SPLIT_BIT_DEF = 16;

    // Snoop write latency in core clock cycles
    localparam int CLK_MHZ = 100;
    localparam int SNOOP_NS = 40;
    localparam int SNOOP_LAT_DEF = (SNOOP_NS * CLK_MHZ) / 1000;

    // Values after reset
    localparam logic RST_VALID = 1'b0;
    localparam logic RST_DIRTY = 1'b0;
    localparam logic RST_LRU = 1'b0;

    // Partitioning of the level2 memory
    typedef enum logic [1:0] {
        L2_ALL_CACHE,
        L2_ALL_RAM,
        L2_MIXED
    } ldc_l2mode_e;

    // Destination of a write arriving on the slave DMA port
    typedef enum logic [1:0] {
        TGT_L2_RAM,
        TGT_L1_RAM,
        TGT_SHARED
    } ldc_target_e;

    // Write-back walk state
    typedef enum logic {
        WALK_IDLE,
        WALK_SCAN
    } ldc_walk_e;

endpackage

// ### hw/ldc_snoop_slot.sv
// One pending snoop write with countdown and cancel
module ldc_snoop_slot #(
    parameter int SET_W = ldc_pkg::SET_W_DEF,
    parameter int DATA_W = ldc_pkg::DATA_W_DEF,
    parameter int LAT = ldc_pkg::SNOOP_LAT_DEF
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [SET_W-1:0] startSet,
    input wire logic startWay,
    input wire logic [DATA_W-1:0] startData,
    input wire logic kill,
    output logic busy,
    output logic done,
    output logic [SET_W-1:0] set,
    output logic way,
    output logic [DATA_W-1:0] data
);
    localparam int CW = $clog2(LAT + 1);
    localparam logic [CW-1:0] LOAD = CW'(LAT - 1);

    logic busy_reg;
    logic [CW-1:0] cnt_reg;

    // A killed snoop never reports done, so stale data never lands
    assign done = busy_reg && (cnt_reg == '0) && !kill;
    assign busy = busy_reg;

    ////////////////////////////////////////////////////////////////////////
    // Occupancy and countdown
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (start && !busy_reg && !kill) begin
            busy_reg <= 1'b1;
            cnt_reg <= LOAD;
        end else if (busy_reg) begin
            if (kill || done) begin
                busy_reg <= 1'b0;
            end
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    // Target line and payload, held while busy
    always_ff @(posedge core_clk) begin
        if (start && !busy_reg) begin
            set <= startSet;
            way <= startWay;
            data <= startData;
        end
    end

endmodule // ldc_snoop_slot

// ### tb/l1_data_cache_snoop_coherence_tb_top.sv
// Self-checking bench for the level1 data cache
module l1_data_cache_snoop_coherence_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LAT = 4;
    logic core_clk, srst, l1RamMode, rd0Valid, rd1Valid, wrValid, dmaValid;
    logic wbReq, cpuReady, dmaReady, rd0Done, rd0Hit, rd1Done, rd1Hit;
    logic ev0Valid, ev1Valid, wtValid, wbDone;
    logic [31:0] rd0Addr, rd1Addr, wrAddr, dmaAddr, wbAddr, ev0Addr, ev1Addr;
    logic [31:0] wtAddr, rd0Fill, rd1Fill, wrData, dmaData, rd0Data, rd1Data;
    logic [31:0] ev0Data, ev1Data, wtData;
    logic [7:0] wbLines;
    ldc_pkg::ldc_l2mode_e l2Mode;
    ldc_pkg::ldc_target_e dmaTarget;
    int errors = 0;
    int samples_checked = 0;

    ldc_l1_data_cache #(.SNOOP_LAT(LAT)) dut (.core_clk(core_clk),
        .srst(srst), .l1RamMode(l1RamMode), .l2Mode(l2Mode),
        .rd0Valid(rd0Valid), .rd0Addr(rd0Addr), .rd0Fill(rd0Fill),
        .rd1Valid(rd1Valid), .rd1Addr(rd1Addr), .rd1Fill(rd1Fill),
        .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
        .dmaValid(dmaValid), .dmaTarget(dmaTarget), .dmaAddr(dmaAddr),
        .dmaData(dmaData), .wbReq(wbReq), .wbAddr(wbAddr),
        .wbLines(wbLines), .cpuReady(cpuReady), .dmaReady(dmaReady),
        .rd0Done(rd0Done), .rd0Hit(rd0Hit), .rd0Data(rd0Data),
        .rd1Done(rd1Done), .rd1Hit(rd1Hit), .rd1Data(rd1Data),
        .ev0Valid(ev0Valid), .ev0Addr(ev0Addr), .ev0Data(ev0Data),
        .ev1Valid(ev1Valid), .ev1Addr(ev1Addr), .ev1Data(ev1Data),
        .wtValid(wtValid), .wtAddr(wtAddr), .wtData(wtData),
        .wbDone(wbDone));
    ldc_l2_model u_l2 (.rd0Valid(rd0Valid), .rd0Addr(rd0Addr),
        .rd1Valid(rd1Valid), .rd1Addr(rd1Addr), .rd0Fill(rd0Fill),
        .rd1Fill(rd1Fill));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Helpers: line address, expected fill word, compare
    function automatic logic [31:0] mk(input int t, input int s);
        return {t[19:0], s[5:0], 6'h00};
    endfunction
    function automatic logic [31:0] fw(input logic [31:0] a);
        return {a[31:6], 6'h00} ^ 32'h5a5a_5a5a;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Every driver task starts and ends just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd2(input logic v0, input logic [31:0] a0,
                       input logic v1, input logic [31:0] a1);
        rd0Valid = v0;
        rd0Addr = a0;
        rd1Valid = v1;
        rd1Addr = a1;
        step(1);
        rd0Valid = 1'b0;
        rd1Valid = 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        wrValid = 1'b1;
        wrAddr = a;
        wrData = d;
        step(1);
        wrValid = 1'b0;
    endtask
    task automatic dma(input ldc_pkg::ldc_target_e t, input logic [31:0] a,
                       input logic [31:0] d);
        dmaValid = 1'b1;
        dmaTarget = t;
        dmaAddr = a;
        dmaData = d;
        step(1);
        dmaValid = 1'b0;
    endtask
    task automatic waitRdy(output int n);
        n = 0;
        while (dmaReady !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Two misses in one cycle into one set land in both ways
    task automatic t_two_way;
        rd2(1'b1, mk(1, 1), 1'b1, mk(2, 1));
        chk({rd0Done, rd1Done, rd0Hit, rd1Hit}, 4'hc);
        chk(rd0Data, fw(mk(1, 1)));
        chk(rd1Data, fw(mk(2, 1)));
        step(1);
        rd2(1'b1, mk(2, 1), 1'b1, mk(1, 1));
        chk({rd0Hit, rd1Hit}, 2'h3);
        chk(rd1Data, fw(mk(1, 1)));
        $display("t_two_way done");
    endtask

    // Dirty data leaves only as a victim; clean victims stay silent
    task automatic t_dirty;
        int dirtyEv = 0;
        int otherEv = 0;
        rd2(1'b1, mk(1, 2), 1'b1, mk(2, 2));
        wr(mk(1, 2), 32'hdead_0001);
        chk(wtValid, 1'b0);
        wr(mk(9, 3), 32'hdead_0002);
        chk(wtValid ? wtAddr : '0, mk(9, 3));
        chk(wtData, 32'hdead_0002);
        for (int i = 0; i < 6; i++) begin
            if (i == 0 || i == 2) rd2(i == 0, mk(3, 2), i == 2, mk(5, 2));
            else step(1);
            if (ev1Valid === 1'b1 && ev1Addr === mk(1, 2)) begin
                dirtyEv++;
                chk(ev1Data, 32'hdead_0001);
            end
            if (ev0Valid === 1'b1 || (ev1Valid === 1'b1 &&
                ev1Addr !== mk(1, 2))) otherEv++;
        end
        chk(dirtyEv, 1);
        chk(otherEv, 0);
        $display("t_dirty done");
    endtask

    // Snoop starts only for level2 RAM traffic on a cached line
    task automatic t_snoop;
        ldc_pkg::ldc_l2mode_e md[6] = '{ldc_pkg::L2_ALL_CACHE,
            ldc_pkg::L2_ALL_RAM, ldc_pkg::L2_ALL_RAM, ldc_pkg::L2_MIXED,
            ldc_pkg::L2_MIXED, ldc_pkg::L2_ALL_RAM};
        ldc_pkg::ldc_target_e tg[6] = '{ldc_pkg::TGT_L2_RAM,
            ldc_pkg::TGT_L1_RAM, ldc_pkg::TGT_SHARED, ldc_pkg::TGT_L2_RAM,
            ldc_pkg::TGT_L2_RAM, ldc_pkg::TGT_L2_RAM};
        logic [5:0] sel = 6'b101000;
        logic [5:0] hit = 6'b110000;
        logic [31:0] cur[2];
        logic [31:0] ad[2];
        int n;
        ad[0] = mk(1, 4);
        ad[1] = mk(17, 4);
        rd2(1'b1, ad[0], 1'b1, ad[1]);
        cur[0] = fw(ad[0]);
        cur[1] = fw(ad[1]);
        for (int i = 0; i < 6; i++) begin
            l2Mode = md[i];
            step(1);
            dma(tg[i], ad[sel[i]], 32'h1000_0000 + i);
            chk(dmaReady, !hit[i]);
            waitRdy(n);
            if (hit[i]) chk(n >= LAT - 1 && n <= LAT + 1, 1'b1);
            if (hit[i]) cur[sel[i]] = 32'h1000_0000 + i;
            rd2(1'b1, ad[0], 1'b1, ad[1]);
            chk({rd0Hit, rd1Hit}, 2'h3);
            chk(rd0Data, cur[0]);
            chk(rd1Data, cur[1]);
        end
        $display("t_snoop done");
    endtask

    // A fill into a snooped line must survive the snoop
    task automatic t_cancel;
        int n;
        l2Mode = ldc_pkg::L2_ALL_RAM;
        rd2(1'b1, mk(1, 5), 1'b1, mk(2, 5));
        rd2(1'b1, mk(1, 5), 1'b0, '0);
        dma(ldc_pkg::TGT_L2_RAM, mk(2, 5), 32'hbad0_0bad);
        chk(dmaReady, 1'b0);
        rd2(1'b1, mk(3, 5), 1'b1, mk(1, 6));
        chk({rd0Hit, rd1Hit}, 2'h0);
        chk(rd0Data, fw(mk(3, 5)));
        chk(rd1Data, fw(mk(1, 6)));
        waitRdy(n);
        chk(n, 0);
        step(LAT);
        rd2(1'b1, mk(3, 5), 1'b1, mk(1, 6));
        chk({rd0Hit, rd1Hit}, 2'h3);
        chk(rd0Data, fw(mk(3, 5)));
        $display("t_cancel done");
    endtask

    // Block write-back and invalidate with completion and refused reads
    task automatic t_walk;
        int doneK = 0;
        int evN = 0;
        int rdN = 0;
        rd2(1'b1, mk(1, 7), 1'b1, mk(1, 8));
        wr(mk(1, 7), 32'hcafe_0007);
        wbReq = 1'b1;
        wbAddr = mk(1, 7);
        wbLines = 8'h02;
        step(1);
        wbReq = 1'b0;
        rd0Valid = 1'b1;
        rd0Addr = mk(1, 8);
        chk(cpuReady, 1'b0);
        for (int k = 1; k < 7; k++) begin
            if (wbDone === 1'b1) doneK = k;
            if (rd0Done === 1'b1) rdN++;
            if (ev0Valid === 1'b1) evN++;
            if (ev0Valid === 1'b1) chk(ev0Data, 32'hcafe_0007);
            if (ev0Valid === 1'b1) chk(ev0Addr, mk(1, 7));
            if (k == 2) rd0Valid = 1'b0;
            step(1);
        end
        chk(doneK, 3);
        chk(evN, 1);
        chk(rdN, 0);
        rd2(1'b1, mk(1, 7), 1'b1, mk(1, 8));
        chk({rd0Hit, rd1Hit}, 2'h0);
        wbReq = 1'b1;
        wbLines = 8'h00;
        step(1);
        wbReq = 1'b0;
        chk(wbDone, 1'b1);
        $display("t_walk done");
    endtask

    // Level1 data RAM mode: never a hit, never an allocation
    task automatic t_l1ram;
        l1RamMode = 1'b1;
        step(1);
        rd2(1'b1, mk(1, 1), 1'b1, mk(9, 9));
        rd2(1'b1, mk(9, 9), 1'b0, '0);
        chk(rd0Hit, 1'b0);
        chk(rd0Data, fw(mk(9, 9)));
        l1RamMode = 1'b0;
        step(1);
        $display("t_l1ram done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog far beyond the test length
    initial begin
        #50us;
        errors++;
        $display("Error at %0t: timeout got %h expected %h", $time, 0, 1);
        test_done;
    end

    // Main sequence
    initial begin
        {srst, l1RamMode, rd0Valid, rd1Valid, wrValid} = 5'b10000;
        {dmaValid, wbReq} = 2'b00;
        {rd0Addr, rd1Addr, wrAddr, dmaAddr, wbAddr} = '0;
        {wrData, dmaData, wbLines} = '0;
        l2Mode = ldc_pkg::L2_ALL_RAM;
        dmaTarget = ldc_pkg::TGT_L2_RAM;
        step(3);
        srst = 1'b0;
        chk({cpuReady, dmaReady, rd0Done, wbDone, ev0Valid}, 5'h18);
        step(1);
        t_two_way();
        t_dirty();
        t_snoop();
        t_cancel();
        t_walk();
        t_l1ram();
        test_done();
    end
endmodule // l1_data_cache_snoop_coherence_tb_top

// ### tb/ldc_l2_model.sv
// Behavioural level2 memory that supplies line fills to both read ports
module ldc_l2_model #(
    parameter int DATA_W = ldc_pkg::DATA_W_DEF
) (
    input wire logic rd0Valid,
    input wire logic [ldc_pkg::ADDR_W-1:0] rd0Addr,
    input wire logic rd1Valid,
    input wire logic [ldc_pkg::ADDR_W-1:0] rd1Addr,
    output logic [DATA_W-1:0] rd0Fill,
    output logic [DATA_W-1:0] rd1Fill
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////
    // Content hangs on the line address only: a 64-byte line is one unit
    function automatic logic [DATA_W-1:0] lineWord(input logic [31:0] a);
        return DATA_W'({a[31:6], 6'h00} ^ 32'h5a5a_5a5a);
    endfunction

    // Outside a request the fill bus shows the inverse
    always_comb begin
        rd0Fill = rd0Valid ? lineWord(rd0Addr) : ~lineWord(rd0Addr);
        rd1Fill = rd1Valid ? lineWord(rd1Addr) : ~lineWord(rd1Addr);
    end
endmodule // ldc_l2_model
